/* File: verilog/cax_pkg.sv */
// Package for the arithmetic, logic, multiply and pointer-jump execution unit.
// Assumes one core clock; shared by the execution unit and its register file.
package cax_pkg;

  // ----------------------------------------------------------------------
  // Operation codes accepted on the command port.
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    CAX_OP_ADD, CAX_OP_ADD_CARRY, CAX_OP_WORD_PLUS_IMMEDIATE,
    CAX_OP_SUB, CAX_OP_MINUS_IMMEDIATE, CAX_OP_MINUS_WITH_BORROW,
    CAX_OP_MINUS_IMMEDIATE_WITH_BORROW, CAX_OP_WORD_MINUS_IMMEDIATE,
    CAX_OP_AND, CAX_OP_MASK_IMMEDIATE, CAX_OP_OR, CAX_OP_MERGE_IMMEDIATE,
    CAX_OP_EXCLUSIVE_TOGGLE, CAX_OP_SET_BITS_BY_MASK,
    CAX_OP_CLEAR_BITS_BY_MASK, CAX_OP_ZERO_SIGN_TEST,
    CAX_OP_PRODUCT_UNSIGNED, CAX_OP_PRODUCT_SIGNED,
    CAX_OP_PRODUCT_SIGNED_BY_UNSIGNED, CAX_OP_FRACTION_PRODUCT_UNSIGNED,
    CAX_OP_FRACTION_PRODUCT_SIGNED, CAX_OP_FRACTION_PRODUCT_MIXED,
    CAX_OP_POINTER_BRANCH, CAX_OP_POINTER_SUBROUTINE_ENTRY
  } cax_op_t;

  // ----------------------------------------------------------------------
  // Status flag bit positions, reset values and cycle counts.
  // ----------------------------------------------------------------------
  localparam int CAX_FLAG_C = 0;
  localparam int CAX_FLAG_Z = 1;
  localparam int CAX_FLAG_N = 2;
  localparam int CAX_FLAG_V = 3;
  localparam int CAX_FLAG_S = 4;
  localparam int CAX_FLAG_H = 5;
  localparam logic [7:0] CAX_STATUS_RESET = 8'h00;
  localparam logic [15:0] CAX_PC_RESET = 16'h0000;
  localparam logic [4:0] CAX_REG_PRODUCT_LOW = 5'h00;
  localparam logic [4:0] CAX_REG_POINTER_LOW = 5'h1E;
  localparam int CAX_CYCLES_WORD = 2;
  localparam int CAX_CYCLES_PRODUCT = 2;
  localparam int CAX_CYCLES_BRANCH = 2;
  localparam int CAX_CYCLES_ENTRY = 3;

endpackage : cax_pkg

/* File: verilog/cax_regfile.sv */
// Register file of the execution unit: 32 general-purpose bytes.
// Assumes writers never hit the same address in one cycle on both ports.
`timescale 1ns/1ps
`default_nettype none
module cax_regfile
  import cax_pkg::*;
#(
  parameter int DEPTH = 32
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [4:0] rd_addr_a,
  input wire logic [4:0] rd_addr_b,
  output logic [7:0] rd_data_a,
  output logic [7:0] rd_data_b,
  input wire logic wr_en_a,
  input wire logic [4:0] wr_addr_a,
  input wire logic [7:0] wr_data_a,
  input wire logic wr_en_b,
  input wire logic [4:0] wr_addr_b,
  input wire logic [7:0] wr_data_b
);

  // Five-bit addresses reach exactly thirty-two bytes; refuse anything else.
  if (DEPTH != 32) begin : g_depth_check
    $error("cax_regfile: DEPTH must be 32");
  end

  logic [7:0] mem [DEPTH];

  // --------------------------------------------------------------------
  // Storage and registered read ports.
  // --------------------------------------------------------------------
  // Reads come from a register, so callers see data one cycle later.
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= 8'h00;
      end
      rd_data_a <= 8'h00;
      rd_data_b <= 8'h00;
    end else begin
      if (wr_en_a) begin
        mem[wr_addr_a] <= wr_data_a;
      end
      if (wr_en_b) begin
        mem[wr_addr_b] <= wr_data_b;
      end
      rd_data_a <= mem[rd_addr_a];
      rd_data_b <= mem[rd_addr_b];
    end
  end

endmodule : cax_regfile
`default_nettype wire

/* File: verilog/cax_exec.sv */
// Execution unit for arithmetic, logic, multiply and pointer jump/call.
// Assumes commands come from the fetch logic on the same clock, one at a
// time, only while busy is low.
// How it works
// - Destination plus source, plus carry if asked; ZCNVH; one cycle.
// - Add immediate to register pair; ZCNVS; two cycles.
// - Subtract register or immediate from destination; ZCNVH; one cycle.
// - Borrow variants also subtract carry; ZCNVH; one cycle.
// - Subtract immediate from register pair; ZCNVS; two cycles.
// - AND, OR with register or constant, XOR with register only; only Z, N, V; one cycle.
// - Set or clear masked destination bits; Z, N, V; one cycle.
// - Test register by ANDing with itself, value unchanged; Z, N, V.
// - Multiply unsigned, signed or mixed into product pair; ZC; two cycles.
// - Fractional multiplies shift product left one bit; Z, C; two cycles.
// - Pointer branch loads PC from pointer pair; no flags; two cycles.
// - Pointer subroutine entry loads PC from pointer pair; three cycles.
`timescale 1ns/1ps
`default_nettype none
module cax_exec
  import cax_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire cax_op_t cmd_op,
  input wire logic [4:0] cmd_dst,
  input wire logic [4:0] cmd_src,
  input wire logic [7:0] cmd_imm,
  input wire logic [4:0] dbg_addr,
  output logic busy,
  output logic done,
  output logic [7:0] status,
  output logic [15:0] pc,
  output logic [7:0] dbg_data
);

  // ----------------------------------------------------------------------
  // State: phase machine and captured command.
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CAX_IDLE, CAX_READ, CAX_EXEC, CAX_HOLD
  } cax_phase_t;

  typedef struct packed {
    cax_phase_t phase;
    cax_op_t op;
    logic [4:0] dst;
    logic [4:0] src;
    logic [7:0] imm;
    logic [1:0] left;
    logic busy;
    logic done;
    logic [7:0] status;
    logic [15:0] pc;
    logic [7:0] dbg;
  } cax_state_t;

  cax_state_t cur;
  cax_state_t nxt;

  logic [4:0] ra;
  logic [4:0] rb;
  logic [7:0] da;
  logic [7:0] db;
  logic wea;
  logic web;
  logic [4:0] wa;
  logic [4:0] wb;
  logic [7:0] wda;
  logic [7:0] wdb;

  // Number of execute cycles for an operation.
  function automatic logic [1:0] cycles_of(input cax_op_t op);
    unique case (op)
      CAX_OP_WORD_PLUS_IMMEDIATE, CAX_OP_WORD_MINUS_IMMEDIATE:
        cycles_of = 2'(CAX_CYCLES_WORD);
      CAX_OP_PRODUCT_UNSIGNED, CAX_OP_PRODUCT_SIGNED,
      CAX_OP_PRODUCT_SIGNED_BY_UNSIGNED, CAX_OP_FRACTION_PRODUCT_UNSIGNED,
      CAX_OP_FRACTION_PRODUCT_SIGNED, CAX_OP_FRACTION_PRODUCT_MIXED:
        cycles_of = 2'(CAX_CYCLES_PRODUCT);
      CAX_OP_POINTER_BRANCH: cycles_of = 2'(CAX_CYCLES_BRANCH);
      CAX_OP_POINTER_SUBROUTINE_ENTRY: cycles_of = 2'(CAX_CYCLES_ENTRY);
      default: cycles_of = 2'h1;
    endcase
  endfunction : cycles_of

  // Byte flags shared by the 8-bit arithmetic and logic paths.
  function automatic logic [7:0] byte_flags(input logic [7:0] r,
      input logic c, input logic v, input logic h, input logic [7:0] old);
    logic [7:0] f;
    f = old;
    f[CAX_FLAG_Z] = (r == 8'h00);
    f[CAX_FLAG_N] = r[7];
    f[CAX_FLAG_V] = v;
    f[CAX_FLAG_C] = c;
    f[CAX_FLAG_H] = h;
    byte_flags = f;
  endfunction : byte_flags

  // Read addresses of an operation: pairs read their high byte on port b.
  // The same decode serves the taking edge and the later phases, so the
  // operands never depend on the command port after it was taken.
  function automatic logic [9:0] read_addrs(input cax_op_t op,
      input logic [4:0] d, input logic [4:0] s);
    unique case (op)
      CAX_OP_WORD_PLUS_IMMEDIATE, CAX_OP_WORD_MINUS_IMMEDIATE:
        read_addrs = {d, d + 5'h01};
      CAX_OP_POINTER_BRANCH, CAX_OP_POINTER_SUBROUTINE_ENTRY:
        read_addrs = {CAX_REG_POINTER_LOW, CAX_REG_POINTER_LOW + 5'h01};
      default: read_addrs = {d, s};
    endcase
  endfunction : read_addrs

  cax_regfile #(.DEPTH(32)) u_regs (
    .mclk(mclk),
    .rst(rst),
    .rd_addr_a(ra),
    .rd_addr_b(rb),
    .rd_data_a(da),
    .rd_data_b(db),
    .wr_en_a(wea),
    .wr_addr_a(wa),
    .wr_data_a(wda),
    .wr_en_b(web),
    .wr_addr_b(wb),
    .wr_data_b(wdb)
  );

  // ----------------------------------------------------------------------
  // Next-state and datapath logic.
  // ----------------------------------------------------------------------
  // Operands are read one cycle ahead, so each operation occupies a read
  // phase plus its execute cycles; the cycle counts below are the execute
  // phase, which is where results are written.
  always_comb begin
    logic [8:0] s9;
    logic [16:0] s17;
    logic [15:0] w;
    logic [15:0] prod;
    logic signed [17:0] sp;
    logic [7:0] opb;
    logic cin;
    logic [7:0] r;
    nxt = cur;
    nxt.done = 1'b0;
    {ra, rb} = read_addrs(cur.op, cur.dst, cur.src);
    wea = 1'b0;
    web = 1'b0;
    wa = cur.dst;
    wb = cur.dst + 5'h01;
    wda = 8'h00;
    wdb = 8'h00;
    s9 = 9'h000;
    s17 = 17'h00000;
    sp = 18'sh00000;
    prod = 16'h0000;
    r = 8'h00;
    w = {db, da};
    opb = (cur.op == CAX_OP_ADD || cur.op == CAX_OP_ADD_CARRY ||
      cur.op == CAX_OP_SUB || cur.op == CAX_OP_MINUS_WITH_BORROW ||
      cur.op == CAX_OP_AND || cur.op == CAX_OP_OR ||
      cur.op == CAX_OP_EXCLUSIVE_TOGGLE) ? db : cur.imm;
    cin = cur.status[CAX_FLAG_C];
    nxt.dbg = da;
    unique case (cur.phase)
      CAX_IDLE: begin
        ra = dbg_addr;
        if (cmd_valid) begin
          // The source is captured too, so the fetch may drop it at once.
          {ra, rb} = read_addrs(cmd_op, cmd_dst, cmd_src);
          nxt.phase = CAX_READ;
          nxt.op = cmd_op;
          nxt.dst = cmd_dst;
          nxt.src = cmd_src;
          nxt.imm = cmd_imm;
          nxt.left = cycles_of(cmd_op);
          nxt.busy = 1'b1;
        end
      end
      CAX_READ: begin
        nxt.phase = CAX_EXEC;
      end
      CAX_EXEC: begin
        unique case (cur.op)
          CAX_OP_ADD, CAX_OP_ADD_CARRY: begin
            s9 = {1'b0, da} + {1'b0, opb} +
              9'((cur.op == CAX_OP_ADD_CARRY) & cin);
            r = s9[7:0];
            wea = 1'b1;
            wda = r;
            nxt.status = byte_flags(r, s9[8],
              (da[7] == opb[7]) && (r[7] != da[7]),
              (({1'b0, da[3:0]} + {1'b0, opb[3:0]} +
                5'((cur.op == CAX_OP_ADD_CARRY) & cin)) > 5'h0F),
              cur.status);
          end
          CAX_OP_SUB, CAX_OP_MINUS_IMMEDIATE, CAX_OP_MINUS_WITH_BORROW,
          CAX_OP_MINUS_IMMEDIATE_WITH_BORROW: begin
            // Borrow variants fold the carry in.
            cin = (cur.op == CAX_OP_MINUS_WITH_BORROW ||
              cur.op == CAX_OP_MINUS_IMMEDIATE_WITH_BORROW) & cin;
            s9 = {1'b0, da} - {1'b0, opb} - 9'(cin);
            r = s9[7:0];
            wea = 1'b1;
            wda = r;
            nxt.status = byte_flags(r, s9[8],
              (da[7] != opb[7]) && (r[7] != da[7]),
              ({1'b0, da[3:0]} < ({1'b0, opb[3:0]} + 5'(cin))),
              cur.status);
          end
          CAX_OP_WORD_PLUS_IMMEDIATE, CAX_OP_WORD_MINUS_IMMEDIATE: begin
            // Second execute cycle writes both bytes of the pair.
            if (cur.left == 2'h1) begin
              s17 = (cur.op == CAX_OP_WORD_PLUS_IMMEDIATE) ?
                {1'b0, w} + {9'h000, cur.imm} :
                {1'b0, w} - {9'h000, cur.imm};
              wea = 1'b1;
              web = 1'b1;
              wda = s17[7:0];
              wdb = s17[15:8];
              nxt.status[CAX_FLAG_Z] = (s17[15:0] == 16'h0000);
              nxt.status[CAX_FLAG_C] = s17[16];
              nxt.status[CAX_FLAG_N] = s17[15];
              nxt.status[CAX_FLAG_V] = (cur.op == CAX_OP_WORD_PLUS_IMMEDIATE) ?
                (!w[15] && s17[15]) : (w[15] && !s17[15]);
              nxt.status[CAX_FLAG_S] = s17[15] ^ nxt.status[CAX_FLAG_V];
            end
          end
          CAX_OP_AND, CAX_OP_MASK_IMMEDIATE, CAX_OP_OR, CAX_OP_MERGE_IMMEDIATE,
          CAX_OP_EXCLUSIVE_TOGGLE, CAX_OP_SET_BITS_BY_MASK,
          CAX_OP_CLEAR_BITS_BY_MASK, CAX_OP_ZERO_SIGN_TEST: begin
            unique case (cur.op)
              CAX_OP_AND, CAX_OP_MASK_IMMEDIATE: r = da & opb;
              CAX_OP_OR, CAX_OP_MERGE_IMMEDIATE: r = da | opb;
              CAX_OP_EXCLUSIVE_TOGGLE: r = da ^ opb;
              CAX_OP_SET_BITS_BY_MASK: r = da | cur.imm;
              CAX_OP_CLEAR_BITS_BY_MASK: r = da & ~cur.imm;
              default: r = da & da;
            endcase
            wea = 1'b1;
            wda = r;
            nxt.status = byte_flags(r, cur.status[CAX_FLAG_C], 1'b0,
              cur.status[CAX_FLAG_H], cur.status);
          end
          CAX_OP_POINTER_BRANCH, CAX_OP_POINTER_SUBROUTINE_ENTRY: begin
            if (cur.left == 2'h1) begin
              nxt.pc = w;
            end
          end
          default: begin
            // Multiplies: product lands in the pair on the last cycle.
            unique case (cur.op)
              // Operands are widened to the product width first, so no
              // tool can size the multiply to eight bits and lose the top.
              CAX_OP_PRODUCT_SIGNED, CAX_OP_FRACTION_PRODUCT_SIGNED:
                sp = $signed({{10{da[7]}}, da}) * $signed({{10{db[7]}}, db});
              CAX_OP_PRODUCT_SIGNED_BY_UNSIGNED, CAX_OP_FRACTION_PRODUCT_MIXED:
                sp = $signed({{10{da[7]}}, da}) * $signed({10'h000, db});
              default: sp = $signed({10'h000, da}) * $signed({10'h000, db});
            endcase
            prod = sp[15:0];
            if (cur.op == CAX_OP_FRACTION_PRODUCT_UNSIGNED ||
                cur.op == CAX_OP_FRACTION_PRODUCT_SIGNED ||
                cur.op == CAX_OP_FRACTION_PRODUCT_MIXED) begin
              prod = {sp[14:0], 1'b0};
            end
            if (cur.left == 2'h1) begin
              wa = CAX_REG_PRODUCT_LOW;
              wb = CAX_REG_PRODUCT_LOW + 5'h01;
              wea = 1'b1;
              web = 1'b1;
              wda = prod[7:0];
              wdb = prod[15:8];
              nxt.status[CAX_FLAG_Z] = (prod == 16'h0000);
              nxt.status[CAX_FLAG_C] = sp[15];
            end
          end
        endcase
        nxt.left = cur.left - 2'h1;
        if (cur.left == 2'h1) begin
          nxt.phase = CAX_HOLD;
          nxt.done = 1'b1;
        end
      end
      CAX_HOLD: begin
        // One settle cycle so the next read sees the written bytes.
        nxt.phase = CAX_IDLE;
        nxt.busy = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      cur <= '{phase: CAX_IDLE, op: CAX_OP_ADD, dst: 5'h00, src: 5'h00,
        imm: 8'h00, left: 2'h0, busy: 1'b0, done: 1'b0,
        status: CAX_STATUS_RESET,
        pc: CAX_PC_RESET, dbg: 8'h00};
    end else begin
      cur <= nxt;
    end
  end

  assign busy = cur.busy;
  assign done = cur.done;
  assign status = cur.status;
  assign pc = cur.pc;
  assign dbg_data = cur.dbg;

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  sequence s_start_entry;
    cur.phase == CAX_IDLE && cmd_valid &&
      cmd_op == CAX_OP_POINTER_SUBROUTINE_ENTRY;
  endsequence

  property p_entry_time;
    @(posedge mclk) disable iff (rst) s_start_entry |-> ##5 done;
  endproperty
  a_entry_time: assert property (p_entry_time)
    else $error("pointer entry did not finish in three execute cycles");

  property p_branch_time;
    @(posedge mclk) disable iff (rst) (cur.phase == CAX_IDLE && cmd_valid &&
      cmd_op == CAX_OP_POINTER_BRANCH) |-> ##4 done;
  endproperty
  a_branch_time: assert property (p_branch_time)
    else $error("pointer branch did not finish in two execute cycles");

  property p_branch_flags;
    @(posedge mclk) disable iff (rst) (cur.phase == CAX_EXEC &&
      (cur.op == CAX_OP_POINTER_BRANCH ||
       cur.op == CAX_OP_POINTER_SUBROUTINE_ENTRY)) |=> $stable(status);
  endproperty
  a_branch_flags: assert property (p_branch_flags)
    else $error("jump changed the status flags");

  property p_product_time;
    @(posedge mclk) disable iff (rst) (cur.phase == CAX_IDLE && cmd_valid &&
      cmd_op == CAX_OP_PRODUCT_UNSIGNED) |-> ##4 done;
  endproperty
  a_product_time: assert property (p_product_time)
    else $error("multiply did not take two execute cycles");

  property p_add_time;
    @(posedge mclk) disable iff (rst) (cur.phase == CAX_IDLE && cmd_valid &&
      cmd_op == CAX_OP_ADD) |-> ##3 done;
  endproperty
  a_add_time: assert property (p_add_time)
    else $error("add did not take one execute cycle");

  property p_logic_keeps_c;
    @(posedge mclk) disable iff (rst) (cur.phase == CAX_EXEC &&
      cur.op == CAX_OP_ZERO_SIGN_TEST) |=> (status[CAX_FLAG_C] ==
      $past(status[CAX_FLAG_C]) && !status[CAX_FLAG_V]);
  endproperty
  a_logic_keeps_c: assert property (p_logic_keeps_c)
    else $error("test changed carry or left overflow set");

  property p_word_time;
    @(posedge mclk) disable iff (rst) (cur.phase == CAX_IDLE && cmd_valid &&
      cmd_op == CAX_OP_WORD_PLUS_IMMEDIATE) |-> ##4 done;
  endproperty
  a_word_time: assert property (p_word_time)
    else $error("word add did not take two execute cycles");

  property p_sub_zero;
    @(posedge mclk) disable iff (rst) (cur.phase == CAX_EXEC &&
      cur.op == CAX_OP_SUB && da == db) |=> status[CAX_FLAG_Z];
  endproperty
  a_sub_zero: assert property (p_sub_zero)
    else $error("equal subtraction did not set zero");

endmodule : cax_exec
`default_nettype wire

/* File: bench/cax_exec_tb.sv */
// Self-checking testbench for the execution unit: a table of operations,
// then pointer branches, a refused command and a reset in mid-run.
// Assumes every register reads zero after reset and that a register can
// be peeked through the debug port once the unit is idle.
`timescale 1ns/1ps
`default_nettype none
module cpu_alu_and_jump_execution_tb_top
  import cax_pkg::*;
;
  `define CHK(got, exp) \
    begin \
      samples_checked++; \
      if ((got) !== (exp)) begin \
        fail_count++; \
        $display("Error at %0t ns: got %0h expected %0h", $time, got, exp); \
      end \
    end

  // --------------------------------------------------------------------
  // Signals, clock and the unit under test.
  // --------------------------------------------------------------------
  logic mclk = 1'b0;
  logic rst;
  logic cmd_valid;
  cax_op_t cmd_op;
  logic [4:0] cmd_dst;
  logic [4:0] cmd_src;
  logic [7:0] cmd_imm;
  logic [4:0] dbg_addr;
  logic busy;
  logic done;
  logic [7:0] status;
  logic [15:0] pc;
  logic [7:0] dbg_data;
  int fail_count = 0;
  int samples_checked = 0;
  int cycle_count = 0;

  // One cycle of 25 ns, toggled every half period.
  always #12.5 mclk = ~mclk;

  cax_exec dut (
    .mclk(mclk),
    .rst(rst),
    .cmd_valid(cmd_valid),
    .cmd_op(cmd_op),
    .cmd_dst(cmd_dst),
    .cmd_src(cmd_src),
    .cmd_imm(cmd_imm),
    .dbg_addr(dbg_addr),
    .busy(busy),
    .done(done),
    .status(status),
    .pc(pc),
    .dbg_data(dbg_data)
  );

  // --------------------------------------------------------------------
  // Operation table: operands, register to inspect, its value, flags.
  // --------------------------------------------------------------------
  typedef struct {
    cax_op_t op;
    logic [4:0] d;
    logic [4:0] s;
    logic [7:0] k;
    logic [4:0] chk;
    logic [7:0] val;
    logic [7:0] st;
  } cax_row_t;

  // Rows are chained: each one starts from the flags the previous left.
  cax_row_t rows [27] = '{
    '{CAX_OP_MERGE_IMMEDIATE,5'h10,5'h00,8'h0F,5'h10,8'h0F,8'h00},
    '{CAX_OP_MERGE_IMMEDIATE,5'h11,5'h00,8'hF8,5'h11,8'hF8,8'h04},
    '{CAX_OP_ADD,5'h10,5'h11,8'h00,5'h10,8'h07,8'h21},
    '{CAX_OP_ADD_CARRY,5'h10,5'h11,8'h00,5'h10,8'h00,8'h23},
    '{CAX_OP_MINUS_WITH_BORROW,5'h11,5'h10,8'h00,5'h11,8'hF7,8'h04},
    '{CAX_OP_SUB,5'h10,5'h11,8'h00,5'h10,8'h09,8'h21},
    '{CAX_OP_MINUS_IMMEDIATE,5'h11,5'h00,8'h79,5'h11,8'h7E,8'h28},
    '{CAX_OP_MINUS_IMMEDIATE,5'h12,5'h00,8'h80,5'h12,8'h80,8'h0D},
    '{CAX_OP_MASK_IMMEDIATE,5'h12,5'h00,8'hC0,5'h12,8'h80,8'h05},
    '{CAX_OP_MINUS_IMMEDIATE_WITH_BORROW,
      5'h11,5'h00,8'h10,5'h11,8'h6D,8'h00},
    '{CAX_OP_OR,5'h10,5'h12,8'h00,5'h10,8'h89,8'h04},
    '{CAX_OP_AND,5'h11,5'h10,8'h00,5'h11,8'h09,8'h00},
    '{CAX_OP_EXCLUSIVE_TOGGLE,5'h11,5'h11,8'h00,5'h11,8'h00,8'h02},
    '{CAX_OP_SET_BITS_BY_MASK,5'h11,5'h00,8'hA0,5'h11,8'hA0,8'h04},
    '{CAX_OP_CLEAR_BITS_BY_MASK,
      5'h11,5'h00,8'h80,5'h11,8'h20,8'h00},
    '{CAX_OP_ZERO_SIGN_TEST,5'h12,5'h12,8'h00,5'h12,8'h80,8'h04},
    '{CAX_OP_WORD_MINUS_IMMEDIATE,
      5'h18,5'h00,8'h01,5'h19,8'hFF,8'h15},
    '{CAX_OP_WORD_PLUS_IMMEDIATE,
      5'h18,5'h00,8'h02,5'h18,8'h01,8'h01},
    '{CAX_OP_PRODUCT_UNSIGNED,5'h10,5'h11,8'h00,5'h01,8'h11,8'h00},
    '{CAX_OP_PRODUCT_SIGNED,5'h12,5'h10,8'h00,5'h01,8'h3B,8'h00},
    '{CAX_OP_PRODUCT_SIGNED_BY_UNSIGNED,
      5'h12,5'h10,8'h00,5'h01,8'hBB,8'h01},
    '{CAX_OP_FRACTION_PRODUCT_UNSIGNED,
      5'h10,5'h11,8'h00,5'h00,8'h40,8'h00},
    '{CAX_OP_FRACTION_PRODUCT_SIGNED,
      5'h12,5'h10,8'h00,5'h01,8'h77,8'h00},
    '{CAX_OP_FRACTION_PRODUCT_MIXED,
      5'h12,5'h10,8'h00,5'h01,8'h77,8'h01},
    '{CAX_OP_PRODUCT_UNSIGNED,5'h11,5'h02,8'h00,5'h00,8'h00,8'h02},
    '{CAX_OP_MERGE_IMMEDIATE,5'h1E,5'h00,8'h34,5'h1E,8'h34,8'h00},
    '{CAX_OP_MERGE_IMMEDIATE,5'h1F,5'h00,8'h92,5'h1F,8'h92,8'h04}
  };

  // --------------------------------------------------------------------
  // Helpers.
  // --------------------------------------------------------------------
  // Edges from the taking edge to the one that shows done: cycles + 1.
  function automatic logic [3:0] exp_cyc(input cax_op_t op);
    if (op == CAX_OP_POINTER_SUBROUTINE_ENTRY) return 4'h4;
    if (op == CAX_OP_POINTER_BRANCH) return 4'h3;
    if (op == CAX_OP_WORD_PLUS_IMMEDIATE) return 4'h3;
    if (op == CAX_OP_WORD_MINUS_IMMEDIATE) return 4'h3;
    if (op >= CAX_OP_PRODUCT_UNSIGNED && op <= CAX_OP_FRACTION_PRODUCT_MIXED)
      return 4'h3;
    return 4'h2;
  endfunction : exp_cyc

  // Issues one command and times it; the wait is bounded so a lost done
  // cannot hang the run.
  task automatic do_op(input cax_op_t op, input logic [4:0] d,
                       input logic [4:0] s, input logic [7:0] k);
    logic [3:0] n;
    n = 4'h0;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_dst = d;
    cmd_src = s;
    cmd_imm = k;
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 4'hF) begin
      @(posedge mclk);
      #1;
      n++;
    end
    `CHK(n, exp_cyc(op))
    @(posedge mclk);
    #1;
    `CHK(done, 1'b0)
    `CHK(busy, 1'b0)
  endtask : do_op

  // The debug read is registered twice, so allow a spare edge.
  task automatic peek(input logic [4:0] a, output logic [7:0] v);
    dbg_addr = a;
    repeat (3) @(posedge mclk);
    #1;
    v = dbg_data;
  endtask : peek

  task automatic close_out();
    $display("Checks made: %0d, mismatches: %0d", samples_checked,
      fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  // A run of a few hundred cycles; the ceiling leaves ample margin.
  always @(posedge mclk) begin
    cycle_count++;
    if (cycle_count == 3000) begin
      fail_count++;
      close_out();
    end
  end

  // --------------------------------------------------------------------
  // Main sequence.
  // --------------------------------------------------------------------
  initial begin
    logic [7:0] v;
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = CAX_OP_ADD;
    cmd_dst = 5'h00;
    cmd_src = 5'h00;
    cmd_imm = 8'h00;
    dbg_addr = 5'h00;
    repeat (5) @(posedge mclk);
    #1;
    rst = 1'b0;
    `CHK(busy, 1'b0)
    `CHK(status, CAX_STATUS_RESET)
    `CHK(pc, CAX_PC_RESET)
    foreach (rows[i]) begin
      do_op(rows[i].op, rows[i].d, rows[i].s, rows[i].k);
      `CHK(status, rows[i].st)
      `CHK(pc, CAX_PC_RESET)
      peek(rows[i].chk, v);
      `CHK(v, rows[i].val)
    end
    // Pointer jumps must move the counter and leave the flags alone.
    do_op(CAX_OP_POINTER_BRANCH, 5'h00, 5'h00, 8'h00);
    `CHK(pc, 16'h9234)
    `CHK(status, 8'h04)
    do_op(CAX_OP_MERGE_IMMEDIATE, 5'h1E, 5'h00, 8'hC1);
    do_op(CAX_OP_POINTER_SUBROUTINE_ENTRY, 5'h00, 5'h00, 8'h00);
    `CHK(pc, 16'h92F5)
    `CHK(status, 8'h04)
    // Equal operands give zero and clear carry, negative and half-carry.
    do_op(CAX_OP_SUB, 5'h1F, 5'h1F, 8'h00);
    `CHK(status, 8'h02)
    peek(5'h1F, v);
    `CHK(v, 8'h00)
    // A command offered while busy must be dropped without trace.
    cmd_valid = 1'b1;
    cmd_op = CAX_OP_WORD_PLUS_IMMEDIATE;
    cmd_dst = 5'h1A;
    cmd_imm = 8'h01;
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
    @(posedge mclk);
    #1;
    `CHK(busy, 1'b1)
    cmd_valid = 1'b1;
    cmd_op = CAX_OP_MERGE_IMMEDIATE;
    cmd_dst = 5'h15;
    cmd_imm = 8'hFF;
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    `CHK(status, 8'h00)
    peek(5'h15, v);
    `CHK(v, 8'h00)
    peek(5'h1A, v);
    `CHK(v, 8'h01)
    // A reset in mid-run clears flags, counter and registers.
    rst = 1'b1;
    @(posedge mclk);
    #1;
    rst = 1'b0;
    `CHK(status, CAX_STATUS_RESET)
    `CHK(pc, CAX_PC_RESET)
    peek(5'h10, v);
    `CHK(v, 8'h00)
    close_out();
  end

  `undef CHK
endmodule : cpu_alu_and_jump_execution_tb_top
`default_nettype wire
